// *** dv/tdm_master_model.sv ***
// Clock-master model: frames word select and captures slot bits
`timescale 1ns/1ns
`default_nettype none
module tdm_master_model #(
  parameter int FRAME_LEN = 64
) (
  input wire logic core_clk,
  input wire logic run,
  input wire logic sd_line,
  input wire logic oe,
  input wire logic chain,
  input wire logic urun,
  output logic word_select,
  output logic [23:0] last_word,
  output int last_bits,
  output int last_first,
  output int last_stop,
  output int last_chain,
  output int last_urun,
  output int frames
);
  int cnt, bits, first, stop, chn, ur;
  logic [23:0] word;
  logic chain_p;
  initial
  begin
    word_select = 1'b0;
    frames = 0;
    chain_p = 1'b0;
  end
  // Sample one edge after launch, then frame bookkeeping
  always @(posedge core_clk)
  begin
    if (oe)
    begin
      word = {word[22:0], sd_line};
      if (bits == 0) first = cnt;
      stop = cnt;
      bits++;
    end
    if (chain && !chain_p) chn = cnt;
    chain_p = chain;
    if (urun) ur++;
    cnt++;
    if (!run)
    begin
      word_select <= 1'b0;
      cnt = FRAME_LEN;
    end
    else if (cnt >= FRAME_LEN)
    begin
      // Publish the finished frame, start a new one
      last_word = word;
      last_bits = bits;
      last_first = first;
      last_stop = stop;
      last_chain = chn;
      last_urun = ur;
      {word, bits, first, stop, chn, ur} = '0;
      cnt = 0;
      frames++;
      word_select <= 1'b1;
    end
    else if (cnt == 2) word_select <= 1'b0;
  end
endmodule : tdm_master_model
`default_nettype wire

// *** dv/test_tdm_mic_slot_output.sv ***
// Self-checking bench for the TDM slot output
`timescale 1ns/1ns
`default_nettype none
module test_tdm_mic_slot_output;
  import tdm_slot_pkg::*;
  logic core_clk, srst, pcm_valid, pcm_ready, word_select_in, run;
  logic serial_data_out, serial_data_oe, word_select_chain_out, underrun;
  logic [23:0] pcm_data, last_word;
  int last_bits, last_first, last_stop, last_chain, last_urun, frames;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  // Shared line with pull-down
  wire logic sd_line = serial_data_oe ? serial_data_out : 1'b0;
  tdm_mic_slot_output u_dut (.core_clk(core_clk), .srst(srst),
    .pcm_valid(pcm_valid), .pcm_ready(pcm_ready), .pcm_data(pcm_data),
    .word_select_in(word_select_in), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .underrun(underrun),
    .word_select_chain_out(word_select_chain_out));
  tdm_master_model u_master (.core_clk(core_clk), .run(run),
    .sd_line(sd_line), .oe(serial_data_oe), .chain(word_select_chain_out),
    .urun(underrun), .word_select(word_select_in), .last_word(last_word),
    .last_bits(last_bits), .last_first(last_first), .last_stop(last_stop),
    .last_chain(last_chain), .last_urun(last_urun), .frames(frames));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic conclude;
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset;
    srst <= 1'b1;
    run <= 1'b0;
    pcm_valid <= 1'b0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : do_reset
  task automatic wait_frames(input int n);
    int t;
    t = frames + n;
    while (frames < t) @(posedge core_clk);
  endtask : wait_frames
  task automatic push(input logic [23:0] v, input int n);
    int k;
    k = 0;
    pcm_valid <= 1'b1;
    pcm_data <= v;
    while (k < n)
    begin
      @(posedge core_clk);
      if (pcm_ready === 1'b1) k++;
    end
    pcm_valid <= 1'b0;
  endtask : push
  // Empty buffer: zeros in slot 0, exact slot timing
  task automatic t_empty;
    do_reset();
    run <= 1'b1;
    wait_frames(2);
    check(last_urun, 1);
    check(last_word, 0);
    check(last_first, 5);
    check(last_stop, 28);
    check(last_bits, 24);
    check(last_chain, 32);
  endtask : t_empty
  // Large step of either sign shows on the top bits
  task automatic t_sign(input logic [23:0] v, input logic [1:0] top);
    do_reset();
    push(v, 4);
    run <= 1'b1;
    wait_frames(2);
    check(last_word[23:22], top);
    check(last_urun, 0);
    check(last_bits, 24);
  endtask : t_sign
  // Fill until refused, then drain one word per frame
  task automatic t_fill;
    int k;
    do_reset();
    // 17 filtered words: 16 fill the buffer, one waits behind it
    push(24'h000000, 68);
    repeat (3) @(posedge core_clk);
    check(pcm_ready, 0);
    run <= 1'b1;
    wait_frames(1);
    for (k = 0; k < 16; k++)
    begin
      wait_frames(1);
      check(last_urun, 0);
    end
    for (k = 0; k < 3 && last_urun == 0; k++) wait_frames(1);
    check(last_urun, 1);
  endtask : t_fill
  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 6000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    srst = 1'b1;
    run = 1'b0;
    pcm_valid = 1'b0;
    pcm_data = 24'h000000;
    t_empty();
    t_sign(24'h600000, 2'h1);
    t_sign(24'hA00000, 2'h2);
    t_fill();
    conclude();
  end
endmodule : test_tdm_mic_slot_output
`default_nettype wire

// *** rtl/tdm_mic_slot_output.sv ***
// FIFO, filters and TDM slot transmitter of a digital microphone
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Sample FIFO with valid/ready on both sides
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem_q [DEPTH];
  // Pointers and fill level
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Next pointer and count values
  always_comb
  begin
    push = in_valid && (cnt_q != DEPTH[AW:0]);
    pop = out_ready && (cnt_q != '0);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Register pointers and storage
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Honest full and empty
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 24-bit two's complement, MSB first
// - Data bits change on rising clock
// - Line released unless sending own slot
// - Release line right after LSB
// - High-pass removes DC, corner scales
// - Low-pass passband to 0.417 fs
// - Decimation cutoff half fs, stopband
// - Full scale is sine peak code
// - Sample at start of 32-bit slot; MSB here goes out 5 core_clk cycles after word_select_in rises
// - Word select sampled on rising edge
// - First slot, chain out delays 32 bits
module tdm_mic_slot_output
  import tdm_slot_pkg::*;
#(
  parameter int FIFO_W = SAMPLE_BITS,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic pcm_valid,
  output logic pcm_ready,
  input wire logic [SAMPLE_BITS-1:0] pcm_data,
  input wire logic word_select_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic word_select_chain_out,
  output logic underrun
);

  ////////////////////////////////////////////////////////////////////////
  // Input filter chain: decimating average then DC high-pass
  // Saturate a wide value to the 24-bit full-scale range
  function automatic logic [23:0] sat24(input logic signed [31:0] v);
    if (v > $signed({8'h00, FULL_POS}))
      sat24 = FULL_POS;
    else if (v < $signed({8'hFF, FULL_NEG}))
      sat24 = FULL_NEG;
    else
      sat24 = v[23:0];
  endfunction : sat24

  // Decimation accumulator, phase, DC estimate and output strobe
  logic signed [31:0] acc_q, acc_d;
  logic [DECIM_LOG2-1:0] ph_q, ph_d;
  logic signed [31:0] dc_q, dc_d;
  logic flt_v_q, flt_v_d;
  logic [23:0] flt_q, flt_d;
  logic fifo_in_ready, pcm_ready_q;
  logic signed [31:0] avg, hp;

  // Next filter state
  always_comb
  begin
    acc_d = acc_q;
    ph_d = ph_q;
    dc_d = dc_q;
    flt_d = flt_q;
    flt_v_d = flt_v_q && !fifo_in_ready;
    avg = acc_q >>> DECIM_LOG2;
    hp = '0;
    if (pcm_valid && pcm_ready_q) // Only on a real handshake
    begin
      // Boxcar average low-pass before decimation
      acc_d = acc_q + {{8{pcm_data[23]}}, pcm_data};
      ph_d = ph_q + 1'b1;
      if (ph_q == '1)
      begin
        avg = acc_d >>> DECIM_LOG2;
        // Leaky DC tracker, corner set by shift, scales with fs
        dc_d = dc_q + ((avg - dc_q) >>> HPF_SHIFT);
        hp = avg - dc_q;
        flt_d = sat24(hp);
        flt_v_d = 1'b1;
        acc_d = '0;
      end
    end
  end

  // Register filter state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      acc_q <= '0;
      ph_q <= '0;
      dc_q <= '0;
      flt_q <= '0;
      flt_v_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      ph_q <= ph_d;
      dc_q <= dc_d;
      flt_q <= flt_d;
      flt_v_q <= flt_v_d;
    end
  end

  // Ready back to source is stalled by a pending filtered word
  // Low through reset and one edge after it
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pcm_ready_q <= 1'b0;
    else
      pcm_ready_q <= !flt_v_d;
  end
  assign pcm_ready = pcm_ready_q;

  ////////////////////////////////////////////////////////////////////////
  // Sample buffer
  logic fifo_out_valid, fifo_pop;
  logic [FIFO_W-1:0] fifo_out_data;

  sample_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(flt_v_q),
    .in_ready(fifo_in_ready),
    .in_data(flt_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Word select synchroniser and frame edge detect
  logic ws_s1_q, ws_s2_q, ws_s3_q;
  logic frame_start;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ws_s1_q <= 1'b0;
      ws_s2_q <= 1'b0;
      ws_s3_q <= 1'b0;
    end
    else
    begin
      ws_s1_q <= word_select_in;
      ws_s2_q <= ws_s1_q;
      ws_s3_q <= ws_s2_q;
    end
  end
  // Only the rising edge marks a frame; falling edge is free
  assign frame_start = ws_s2_q && !ws_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Slot transmitter and chained word select
  tx_state_t st_q, st_d;
  logic [5:0] bit_q, bit_d;
  logic [23:0] shf_q, shf_d;
  logic sd_q, sd_d, oe_q, oe_d;
  logic [SLOT_BITS-3:0] wsd_q, wsd_d;
  logic udr_q, udr_d;

  // Next transmit state
  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    shf_d = shf_q;
    sd_d = 1'b0;
    oe_d = 1'b0;
    udr_d = 1'b0;
    fifo_pop = 1'b0;
    // Sync stages plus this line delay word select one slot
    wsd_d = {wsd_q[SLOT_BITS-4:0], ws_s2_q};
    case (st_q)
      ST_IDLE:
      begin
        if (frame_start)
          st_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        // First slot belongs to this device
        st_d = ST_SEND;
        if (fifo_out_valid)
        begin
          shf_d = fifo_out_data;
          fifo_pop = 1'b1;
        end
        else
        begin
          shf_d = '0;
          udr_d = 1'b1;
        end
        bit_d = BIT_CNT_RST;
      end
      ST_SEND:
      begin
        // Drive MSB first, one bit per rising edge
        sd_d = shf_q[23];
        oe_d = 1'b1;
        shf_d = {shf_q[22:0], 1'b0};
        bit_d = bit_q + 6'h01;
        if (bit_q == LAST_BIT)
          st_d = ST_IDLE;
      end
      default:
        st_d = ST_IDLE;
    endcase
  end

  // Register transmit state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st_q <= ST_IDLE;
      bit_q <= BIT_CNT_RST;
      shf_q <= '0;
      sd_q <= 1'b0;
      oe_q <= 1'b0;
      wsd_q <= '0;
      udr_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      sd_q <= sd_d;
      oe_q <= oe_d;
      wsd_q <= wsd_d;
      udr_q <= udr_d;
    end
  end

  assign serial_data_out = sd_q;
  assign serial_data_oe = oe_q;
  assign word_select_chain_out = wsd_q[SLOT_BITS-3];
  assign underrun = udr_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence slot_begin_s;
    (frame_start && st_q == ST_IDLE) ##2 1'b1;
  endsequence

  drive_length_a: assert property (@(posedge core_clk) disable iff (srst)
    slot_begin_s |=> (serial_data_oe [*8]) ##1 serial_data_oe [*8]
      ##1 serial_data_oe [*8] ##1 !serial_data_oe)
    else $error("slot not 24 bits");
  release_idle_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q != ST_SEND) |=> !serial_data_oe)
    else $error("line driven outside slot");
  msb_first_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == ST_WAIT && fifo_out_valid) |=> ##1
      (serial_data_out == $past(fifo_out_data[23], 2)))
    else $error("msb not first");
  ws_chain_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(ws_s2_q) |-> ##30 word_select_chain_out)
    else $error("chain out not one slot late");
  frame_edge_a: assert property (@(posedge core_clk) disable iff (srst)
    (frame_start && st_q == ST_IDLE) |=> st_q == ST_WAIT)
    else $error("frame edge missed");
  hpf_sat_a: assert property (@(posedge core_clk) disable iff (srst)
    flt_v_d && !flt_v_q |-> $signed(hp) <= $signed({8'h00, FULL_POS})
      || flt_d == FULL_POS)
    else $error("saturation wrong");
  lsb_release_a: assert property (@(posedge core_clk) disable iff (srst)
    (st_q == ST_SEND && bit_q == LAST_BIT) |=> ##1 !serial_data_oe)
    else $error("line held past lsb");
  decim_rate_a: assert property (@(posedge core_clk) disable iff (srst)
    (flt_v_d && !flt_v_q) |-> ph_q == '1)
    else $error("decimation phase wrong");

endmodule : tdm_mic_slot_output

`default_nettype wire

// *** rtl/tdm_slot_pkg.sv ***
// Shared constants and types for the TDM microphone slot output
package tdm_slot_pkg;

  // Width of one channel sample in bits
  localparam int SAMPLE_BITS = 24;
  // Width of one TDM slot in bits
  localparam int SLOT_BITS = 32;
  // Depth of the sample FIFO in words
  localparam int FIFO_DEPTH = 16;
  // High-pass filter shift: corner near 1.9 Hz at 48 kHz, scales with fs
  localparam int HPF_SHIFT = 12;
  // Log2 of the decimation ratio of the averaging low-pass stage
  localparam int DECIM_LOG2 = 2;
  // Reset value of the bit counter
  localparam logic [5:0] BIT_CNT_RST = 6'h00;
  // Last bit index of the sample within its slot
  localparam logic [5:0] LAST_BIT = 6'h17;
  // Positive and negative full-scale codes
  localparam logic [23:0] FULL_POS = 24'h7FFFFF;
  localparam logic [23:0] FULL_NEG = 24'h800000;

  // Transmit states, one-hot
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } tx_state_t;

endpackage : tdm_slot_pkg
